/* File: verilog/svb_bank_regs.vh */
// Offsets, field positions, reset values and codes of the switch config bank
`ifndef SVB_BANK_REGS_VH
`define SVB_BANK_REGS_VH
`define SVB_OFF_VLAN8      8'hb0
`define SVB_OFF_VLAN9      8'hb4
`define SVB_OFF_VLAN10     8'hb8
`define SVB_OFF_VLAN11     8'hbc
`define SVB_OFF_VLAN12     8'hc0
`define SVB_OFF_VLAN13     8'hc4
`define SVB_OFF_VLAN14     8'hc8
`define SVB_OFF_VLAN15     8'hcc
`define SVB_OFF_SWAP       8'hd0
`define SVB_OFF_START      8'hd4
`define SVB_OFF_MCAST      8'hd8
`define SVB_OFF_IND        8'hdc
`define SVB_VLAN_FWD_LO    0
`define SVB_VLAN_TAG_LO    3
`define SVB_VLAN_VID_LO    6
`define SVB_VLAN_VALID     18
`define SVB_VLAN_W         19
`define SVB_START_WR       15
`define SVB_START_RD       31
`define SVB_MC_SRC_DROP    0
`define SVB_MC_UNK_ACT     1
`define SVB_MC_SNOOP_LO    2
`define SVB_MC_SNOOP_EN    7
`define SVB_MC_RSV_MASK    32'h0303_0300
`define SVB_IND_EN_LO      24
`define SVB_IND_W          26
`define SVB_RST_WORD       32'h0000_0000
`define SVB_SWAP_NONE      2'h0
`define SVB_SWAP_REV       2'h1
`define SVB_SWAP_HALF      2'h2
`define SVB_SWAP_PAIR      2'h3
`define SVB_NH_HOPOPT      8'h00
`define SVB_NH_ICMP4       8'h01
`define SVB_NH_ICMP6       8'h3a
`define SVB_NH_ROUTE       8'h2b
`define SVB_NH_FRAG        8'h2c
`define SVB_NH_ESP         8'h32
`define SVB_NH_AUTH        8'h33
`define SVB_NH_DSTOPT      8'h3c
`define SVB_HOP_ONE        8'h01
`endif

/* File: verilog/svb_bank.v */
// Switch VLAN entries 8-15, host byte order, packet start, multicast policy, indicators
`timescale 1ns/1ns
`default_nettype none
`include "svb_bank_regs.vh"

module svb_bank #(
	parameter AW = 8
) (
	input  wire          clk,             // System clock, 10 MHz
	input  wire          rst_b,           // Synchronous reset, active low
	input  wire [AW-1:0] reg_addr,        // Register byte address
	input  wire [31:0]   reg_wdata,       // Register write data
	input  wire          reg_wr,          // Write strobe
	input  wire          reg_rd,          // Read strobe
	output reg  [31:0]   reg_rdata,       // Read data, cycle after strobe
	input  wire [31:0]   host_din,        // Host data word to reorder
	input  wire          host_din_vld,    // Host data word valid
	output reg  [31:0]   host_dout,       // Reordered host data word
	output reg           host_dout_vld,   // Reordered word valid
	output reg           host_write_begin, // Packet-input start bit
	output reg           host_read_begin, // Packet-output start bit
	input  wire          vq_vld,          // VLAN lookup request
	input  wire [11:0]   vq_vid,          // VID to look up
	output reg           vq_done,         // Lookup answer strobe
	output reg           vq_hit,          // A valid entry matched
	output reg  [2:0]    vq_member,       // Membership mask of match
	output reg  [2:0]    vq_tag,          // Egress tag mask of match
	input  wire          pk_vld,          // Frame attributes valid
	input  wire          pk_l2_mc_reg,    // Registered L2 multicast
	input  wire          pk_src_in_grp,   // Source port in group map
	input  wire          pk_ip_mc,        // IP multicast frame
	input  wire          pk_igmp_hit,     // IGMP table match
	input  wire          pk_ipv6,         // IPv6 frame
	input  wire          pk_v6_mc,        // IPv6 multicast destination
	input  wire          pk_icmp4,        // ICMPv4 frame
	input  wire [7:0]    pk_next_hdr,     // IPv6 next header
	input  wire [7:0]    pk_ext_hdr,      // Next header of first extension
	input  wire [7:0]    pk_hop,          // Hop limit or TTL
	output reg           pk_done,         // Decision strobe
	output reg           pk_drop,         // Drop the frame
	output reg           pk_flood,        // Broadcast the frame
	output reg           pk_cpu_copy,     // Copy frame to CPU port
	input  wire [7:0]    phy0_stat,       // PHY0 link conditions, async
	input  wire [7:0]    phy1_stat,       // PHY1 link conditions, async
	output reg  [2:0]    phy0_led_n,      // PHY0 indicators, low lit
	output reg  [2:0]    phy1_led_n       // PHY1 indicators, low lit
);

	localparam NV = 8;

	// Storage plan
	// Eight VLAN words live in one small array, indexed by word offset from entry 8.
	// Only the nineteen defined bits of each entry are kept; the rest read zero.
	// Policy keeps its reserved read-write pairs so software sees them come back.
	// Indicator control keeps selects and the two enable bits, nothing above.
	// Start bits are plain levels that software sets and clears itself.
	//
	// Timing plan
	// Every answer (read data, lookup, frame decision, reordered word) is
	// registered, so each leaves one clock after the strobe that asked for it.
	// Indicators see PHY status through two flops, then one more for the pins,
	// so a status change reaches a pin on the third edge.
	//
	// Hazards kept in mind
	// Read data drops back to zero outside its answer cycle, so a stale word
	// never looks like a fresh answer to a master that samples late.
	// A write and a read to the same word in one cycle never happen here,
	// as the master never raises both strobes together.

	reg  [`SVB_VLAN_W-1:0] vlan_mem [0:NV-1];
	reg  [1:0]             host_byte_swap_select;
	reg  [31:0]            multicast_policy_control;
	reg  [`SVB_IND_W-1:0]  indicator_control;
	reg  [31:0]            next_rdata;
	reg  [31:0]            next_dout;
	reg  [15:0]            stat_meta;
	reg  [15:0]            stat_sync;
	wire [NV-1:0]          vhit;
	wire                   vlan_sel;
	wire [2:0]             vlan_idx;
	wire [7:0]             off;
	wire                   mcast_source_port_drop;
	wire                   unknown_ip_mcast_action;
	wire [4:0]             v6_snoop_select;
	wire                   v6_snoop_enable;
	wire [7:0]             indicator0_source_select;
	wire [7:0]             indicator1_source_select;
	wire [7:0]             indicator2_source_select;
	wire [1:0]             ind_en;
	wire [5:0]             next_led_n;
	wire                   nh_is1;
	wire                   nh_is58;
	wire                   nh_ext;
	wire                   hop1;
	wire                   snoop_cpu;
	integer                i;

	// Field views of the policy and indicator registers
	assign mcast_source_port_drop   = multicast_policy_control[`SVB_MC_SRC_DROP];
	assign unknown_ip_mcast_action  = multicast_policy_control[`SVB_MC_UNK_ACT];
	assign v6_snoop_select          = multicast_policy_control[`SVB_MC_SNOOP_LO+4:`SVB_MC_SNOOP_LO];
	assign v6_snoop_enable          = multicast_policy_control[`SVB_MC_SNOOP_EN];
	assign indicator0_source_select = indicator_control[7:0];
	assign indicator1_source_select = indicator_control[15:8];
	assign indicator2_source_select = indicator_control[23:16];
	assign ind_en                   = indicator_control[`SVB_IND_EN_LO+1:`SVB_IND_EN_LO];

	// VLAN entries sit on consecutive words from entry 8 up
	// The range test and the alignment test together pick a VLAN word.
	// An unaligned address inside the range selects nothing at all.
	// The offset subtraction wraps below entry 8, but then the range test fails.
	assign off      = reg_addr[7:0] - `SVB_OFF_VLAN8;
	assign vlan_sel = (reg_addr >= `SVB_OFF_VLAN8) && (reg_addr <= `SVB_OFF_VLAN15)
	                  && (reg_addr[1:0] == 2'h0);
	assign vlan_idx = off[4:2];

	// Register writes; only defined fields store, reserved read-only bits drop
	// Each register keeps only the bits it owns, so reserved read-only bits
	// cannot be set by a write of all ones.
	// Unmapped addresses fall to the empty default branch and change nothing.
	// A VLAN word write updates all fields of that entry in one cycle, so a
	// lookup never sees half of an old entry and half of a new one.
	always @(posedge clk) begin
		if (!rst_b) begin
			for (i = 0; i < NV; i = i + 1) begin
				vlan_mem[i] <= {`SVB_VLAN_W{1'b0}};
			end
			host_byte_swap_select    <= 2'h0;
			host_write_begin         <= 1'b0;
			host_read_begin          <= 1'b0;
			multicast_policy_control <= `SVB_RST_WORD;
			indicator_control        <= {`SVB_IND_W{1'b0}};
		end else if (reg_wr) begin
			if (vlan_sel) begin
				vlan_mem[vlan_idx] <= reg_wdata[`SVB_VLAN_W-1:0];
			end
			case (reg_addr)
				`SVB_OFF_SWAP: begin
					host_byte_swap_select <= reg_wdata[1:0];
				end
				`SVB_OFF_START: begin
					host_write_begin <= reg_wdata[`SVB_START_WR];
					host_read_begin  <= reg_wdata[`SVB_START_RD];
				end
				`SVB_OFF_MCAST: begin
					multicast_policy_control <= reg_wdata & (`SVB_MC_RSV_MASK | 32'h0000_00ff);
				end
				`SVB_OFF_IND: begin
					indicator_control <= reg_wdata[`SVB_IND_W-1:0];
				end
				default: begin
				end
			endcase
		end
	end

	// Read mux; unmapped addresses and reserved read-only bits read zero
	// Start bits return in their own positions, all other bits zero.
	// Policy returns its stored word; the write mask already cleared spares.
	// Indicator control is padded with zeros above the enable field.
	always @* begin
		next_rdata = `SVB_RST_WORD;
		if (vlan_sel) begin
			next_rdata = {13'h0000, vlan_mem[vlan_idx]};
		end else begin
			case (reg_addr)
				`SVB_OFF_SWAP:  next_rdata = {30'h0000_0000, host_byte_swap_select};
				`SVB_OFF_START: next_rdata = {host_read_begin, 15'h0000, host_write_begin, 15'h0000};
				`SVB_OFF_MCAST: next_rdata = multicast_policy_control;
				`SVB_OFF_IND:   next_rdata = {6'h00, indicator_control};
				default:        next_rdata = `SVB_RST_WORD;
			endcase
		end
	end

	// Read data register, holds zero outside read answers
	always @(posedge clk) begin
		if (!rst_b) begin
			reg_rdata <= `SVB_RST_WORD;
		end else if (reg_rd) begin
			reg_rdata <= next_rdata;
		end else begin
			reg_rdata <= `SVB_RST_WORD;
		end
	end

	// Host data byte reorder
	// Byte 3 is the top byte of the word, byte 0 the bottom one.
	// The selector is read at the edge that takes the word, so a change of
	// code between two words affects only the later one.
	always @* begin
		case (host_byte_swap_select)
			`SVB_SWAP_NONE: next_dout = host_din;
			`SVB_SWAP_REV:  next_dout = {host_din[7:0], host_din[15:8], host_din[23:16], host_din[31:24]};
			`SVB_SWAP_HALF: next_dout = {host_din[23:16], host_din[31:24], host_din[7:0], host_din[15:8]};
			`SVB_SWAP_PAIR: next_dout = {host_din[15:8], host_din[7:0], host_din[31:24], host_din[23:16]};
			default:        next_dout = host_din;
		endcase
	end

	// Reordered word leaves one cycle after it enters
	always @(posedge clk) begin
		if (!rst_b) begin
			host_dout     <= `SVB_RST_WORD;
			host_dout_vld <= 1'b0;
		end else begin
			host_dout_vld <= host_din_vld;
			if (host_din_vld) begin
				host_dout <= next_dout;
			end
		end
	end

	// Per-entry VID compare; VID 0 is outside the usable range
	// One comparator per entry; all eight work in parallel in one cycle.
	// An entry with its valid bit clear never matches, whatever VID it holds.
	genvar g;
	generate
		for (g = 0; g < NV; g = g + 1) begin : g_vlan
			assign vhit[g] = vlan_mem[g][`SVB_VLAN_VALID]
			                 && (vq_vid != 12'h000)
			                 && (vlan_mem[g][`SVB_VLAN_VID_LO+11:`SVB_VLAN_VID_LO] == vq_vid);
		end
	endgenerate

	// Lookup answer; lowest matching entry wins
	// The loop runs from the top entry down, so the last hit written,
	// the lowest index, is the one that stands.
	// A miss answers with both masks cleared, never with old masks.
	always @(posedge clk) begin
		if (!rst_b) begin
			vq_done   <= 1'b0;
			vq_hit    <= 1'b0;
			vq_member <= 3'h0;
			vq_tag    <= 3'h0;
		end else begin
			vq_done <= vq_vld;
			if (vq_vld) begin
				vq_hit    <= |vhit;
				vq_member <= 3'h0;
				vq_tag    <= 3'h0;
				for (i = NV - 1; i >= 0; i = i - 1) begin
					if (vhit[i]) begin
						vq_member <= vlan_mem[i][`SVB_VLAN_FWD_LO+2:`SVB_VLAN_FWD_LO];
						vq_tag    <= vlan_mem[i][`SVB_VLAN_TAG_LO+2:`SVB_VLAN_TAG_LO];
					end
				end
			end
		end
	end

	// IPv6 header classification for snooping
	// Hop-by-hop options (next header 0) look one header further in.
	// Only the first extension header is inspected; deeper chains are not.
	assign hop1    = (pk_hop == `SVB_HOP_ONE);
	assign nh_ext  = (pk_next_hdr == `SVB_NH_HOPOPT);
	assign nh_is1  = (pk_next_hdr == `SVB_NH_ICMP4) || (nh_ext && pk_ext_hdr == `SVB_NH_ICMP4);
	assign nh_is58 = (pk_next_hdr == `SVB_NH_ICMP6) || (nh_ext && pk_ext_hdr == `SVB_NH_ICMP6);

	// Snoop terms, all gated by the enable bit
	// Select bits 2 and 3 do the same job; either one turns the term on.
	// The copy to the CPU port does not change drop or flood.
	assign snoop_cpu = v6_snoop_enable && (
	    (v6_snoop_select[0] && pk_ipv6 && pk_v6_mc && hop1 && nh_is1)
	 || (v6_snoop_select[1] && pk_ipv6 && pk_v6_mc && hop1 && nh_is58)
	 || ((v6_snoop_select[2] || v6_snoop_select[3]) && (pk_icmp4 || pk_ipv6) && hop1)
	 || (v6_snoop_select[4] && pk_ipv6 && ((pk_next_hdr == `SVB_NH_ROUTE)
	     || (pk_next_hdr == `SVB_NH_FRAG) || (pk_next_hdr == `SVB_NH_ESP)
	     || (pk_next_hdr == `SVB_NH_AUTH) || (pk_next_hdr == `SVB_NH_DSTOPT))));

	// Forwarding decisions, one cycle after the attributes
	// The source-port rule is tested first and wins over the IP rule.
	// A frame matching neither rule is neither dropped nor flooded here.
	// Decisions hold until the next frame is presented.
	always @(posedge clk) begin
		if (!rst_b) begin
			pk_done     <= 1'b0;
			pk_drop     <= 1'b0;
			pk_flood    <= 1'b0;
			pk_cpu_copy <= 1'b0;
		end else begin
			pk_done <= pk_vld;
			if (pk_vld) begin
				pk_drop     <= 1'b0;
				pk_flood    <= 1'b0;
				pk_cpu_copy <= snoop_cpu;
				if (pk_l2_mc_reg && !pk_src_in_grp) begin
					pk_drop  <= mcast_source_port_drop;
					pk_flood <= !mcast_source_port_drop;
				end else if (pk_ip_mc && !pk_igmp_hit) begin
					pk_drop  <= !unknown_ip_mcast_action;
					pk_flood <= unknown_ip_mcast_action;
				end
			end
		end
	end

	// Two-flop synchroniser for PHY status
	// Status pins come from the PHY's own timing and may change anywhere.
	// Only the second flop feeds logic; the first may go metastable.
	// Each bit is synchronised alone; a short glitch may blink one pin once.
	always @(posedge clk) begin
		if (!rst_b) begin
			stat_meta <= 16'h0000;
			stat_sync <= 16'h0000;
		end else begin
			stat_meta <= {phy1_stat, phy0_stat};
			stat_sync <= stat_meta;
		end
	end

	// Indicator drive per PHY and pin: any selected condition lights it
	// Entries 0 to 2 belong to PHY0, entries 3 to 5 to PHY1.
	// Pin i of a PHY uses select field i against that PHY's status.
	// A disabled PHY keeps all its pins high, which is dark.
	generate
		for (g = 0; g < 6; g = g + 1) begin : g_led
			assign next_led_n[g] = ~(ind_en[g/3]
			    & |(indicator_control[(g%3)*8 +: 8] & stat_sync[(g/3)*8 +: 8]));
		end
	endgenerate

	// Indicator outputs, dark (high) in reset
	// Registered so that pins never glitch on combinational settling.
	always @(posedge clk) begin
		if (!rst_b) begin
			phy0_led_n <= 3'h7;
			phy1_led_n <= 3'h7;
		end else begin
			phy0_led_n <= next_led_n[2:0];
			phy1_led_n <= next_led_n[5:3];
		end
	end

endmodule
`default_nettype wire

/* File: sim/svb_bank_checker.sv */
// Port assertions for the switch config bank
`timescale 1ns/1ns
`default_nettype none
`include "svb_bank_regs.vh"
module svb_bank_checker #(
	parameter AW = 8
) (
	input wire          clk,           // Clock
	input wire          rst_b,         // Reset, active low
	input wire [AW-1:0] reg_addr,      // Register address
	input wire [31:0]   reg_wdata,     // Write data
	input wire          reg_wr,        // Write strobe
	input wire          reg_rd,        // Read strobe
	input wire [31:0]   reg_rdata,     // Read data
	input wire          host_din_vld,  // Host word in
	input wire          host_dout_vld, // Host word out
	input wire          vq_vld,        // Lookup request
	input wire [11:0]   vq_vid,        // Lookup VID
	input wire          vq_done,       // Lookup answer
	input wire          vq_hit,        // Lookup hit
	input wire [2:0]    vq_member,     // Member mask
	input wire [2:0]    vq_tag,        // Tag mask
	input wire          pk_vld,        // Frame request
	input wire          pk_done,       // Frame answer
	input wire          pk_drop,       // Drop decision
	input wire          pk_flood,      // Flood decision
	input wire [2:0]    phy0_led_n,    // PHY0 indicators
	input wire [2:0]    phy1_led_n     // PHY1 indicators
);
	reg [1:0] en; // Shadow of the indicator enable field
	// Follow host writes of the enable field
	always @(posedge clk) begin
		if (!rst_b)
			en <= 2'h0;
		else if (reg_wr && reg_addr == `SVB_OFF_IND)
			en <= reg_wdata[25:24];
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	property p_rd_idle; !reg_rd |=> reg_rdata == 32'h0000_0000; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside answer cycle");
	property p_vl_rsv; reg_rd && reg_addr >= `SVB_OFF_VLAN8 && reg_addr <= `SVB_OFF_VLAN15 |=> reg_rdata[31:19] == 13'h0000; endproperty
	a_vl_rsv: assert property (p_vl_rsv) else $error("vlan entry spare bits set");
	property p_mc_rsv; reg_rd && reg_addr == `SVB_OFF_MCAST |=> (reg_rdata & 32'hfcfc_fc00) == 32'h0000_0000; endproperty
	a_mc_rsv: assert property (p_mc_rsv) else $error("policy spare bits set");
	property p_din; host_din_vld |=> host_dout_vld; endproperty
	a_din: assert property (p_din) else $error("reordered word missing");
	property p_dout; host_dout_vld |-> $past(host_din_vld); endproperty
	a_dout: assert property (p_dout) else $error("reordered word without input");
	property p_vq; vq_vld |=> vq_done; endproperty
	a_vq: assert property (p_vq) else $error("lookup answer missing");
	property p_vq0; vq_vld && vq_vid == 12'h000 |=> !vq_hit; endproperty
	a_vq0: assert property (p_vq0) else $error("vid zero matched");
	property p_miss; vq_done && !vq_hit |-> vq_member == 3'h0 && vq_tag == 3'h0; endproperty
	a_miss: assert property (p_miss) else $error("miss with masks");
	property p_pk; pk_vld |=> pk_done && !(pk_drop && pk_flood); endproperty
	a_pk: assert property (p_pk) else $error("bad frame decision");
	property p_led0; !en[0] [*4] |-> phy0_led_n == 3'h7; endproperty
	a_led0: assert property (p_led0) else $error("PHY0 lit while disabled");
	property p_led1; !en[1] [*4] |-> phy1_led_n == 3'h7; endproperty
	a_led1: assert property (p_led1) else $error("PHY1 lit while disabled");
endmodule
bind svb_bank svb_bank_checker #(.AW(AW)) chk (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .host_din_vld(host_din_vld), .host_dout_vld(host_dout_vld),
	.vq_vld(vq_vld), .vq_vid(vq_vid), .vq_done(vq_done), .vq_hit(vq_hit), .vq_member(vq_member), .vq_tag(vq_tag),
	.pk_vld(pk_vld), .pk_done(pk_done), .pk_drop(pk_drop), .pk_flood(pk_flood), .phy0_led_n(phy0_led_n),
	.phy1_led_n(phy1_led_n));
`default_nettype wire

/* File: sim/svb_host_model.sv */
// Host processor model feeding words to the host data port
`timescale 1ns/1ns
`default_nettype none
module svb_host_model (
	input  wire        clk,      // Clock
	input  wire        begin_ok, // Write-begin bit from the bank
	input  wire        send,     // Send one word
	input  wire [31:0] word,     // Word to send
	output reg  [31:0] din,      // Host data lines
	output reg         din_vld   // Word valid
);
	initial begin
		din = 32'h0000_0000;
		din_vld = 1'b0;
	end
	// Words go out only after write-begin is set; idle lines toggle
	always @(posedge clk) begin
		din_vld <= send && begin_ok;
		din <= (send && begin_ok) ? word : ~din;
	end
endmodule
`default_nettype wire

/* File: sim/svb_bank_tb.sv */
// Self-checking bench for the switch config bank
`timescale 1ns/1ns
`default_nettype none
`include "svb_bank_regs.vh"
module testbench;
	localparam [127:0] SWP = 128'h2211_4433_3344_1122_1122_3344_4433_2211;
	localparam [39:0]  NHX = 40'h2b_2c32_333c;
	reg         clk, rst_b, reg_wr, reg_rd, send, vq_vld, pk_vld;
	reg  [7:0]  reg_addr, nh, ex, hop, st0, st1;
	reg  [31:0] reg_wdata;
	reg  [11:0] vq_vid;
	reg  [6:0]  at;
	wire [31:0] reg_rdata, din, host_dout;
	wire        din_vld, host_dout_vld, wbeg, rbeg, vq_done, vq_hit, pk_done, pk_drop, pk_flood, cpu;
	wire [2:0]  vq_member, vq_tag, led0_n, led1_n;
	integer     mismatches, checks_done, cycles, i;
	svb_bank #(.AW(8)) dut (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .host_din(din), .host_din_vld(din_vld), .host_dout(host_dout),
		.host_dout_vld(host_dout_vld), .host_write_begin(wbeg), .host_read_begin(rbeg), .vq_vld(vq_vld),
		.vq_vid(vq_vid), .vq_done(vq_done), .vq_hit(vq_hit), .vq_member(vq_member), .vq_tag(vq_tag), .pk_vld(pk_vld),
		.pk_l2_mc_reg(at[6]), .pk_src_in_grp(at[5]), .pk_ip_mc(at[4]), .pk_igmp_hit(at[3]), .pk_ipv6(at[2]),
		.pk_v6_mc(at[1]), .pk_icmp4(at[0]), .pk_next_hdr(nh), .pk_ext_hdr(ex), .pk_hop(hop), .pk_done(pk_done),
		.pk_drop(pk_drop), .pk_flood(pk_flood), .pk_cpu_copy(cpu), .phy0_stat(st0), .phy1_stat(st1),
		.phy0_led_n(led0_n), .phy1_led_n(led1_n));
	svb_host_model host (.clk(clk), .begin_ok(wbeg), .send(send), .word(32'h4433_2211), .din(din), .din_vld(din_vld));
	// Clock and hang guard
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles = cycles + 1;
		if (cycles == 5000) begin
			mismatches = mismatches + 1;
			end_sim;
		end
	end
	task end_sim;
		begin
			if (mismatches == 0 && checks_done > 0)
				$display("All checks passed");
			else
				$display("Checks failed");
			$finish;
		end
	endtask
	task chk(input [31:0] seen, input [31:0] exp);
		begin
			checks_done = checks_done + 1;
			if (seen !== exp) begin
				mismatches = mismatches + 1;
				$display("Error at %0t: saw %h, expected %h", $time, seen, exp);
			end
		end
	endtask
	function [7:0] rad(input integer k);
		rad = 8'hb0 + k[5:0] * 6'h04;
	endfunction
	function [31:0] msk(input integer k);
		msk = k < 8 ? 32'h0007_ffff : k == 8 ? 32'h0000_0003 : k == 9 ? 32'h8000_8000 : k == 10 ? 32'h0303_03ff :
			32'h03ff_ffff;
	endfunction
	task wr(input [7:0] a, input [31:0] d);
		begin
			@(posedge clk);
			reg_addr <= a;
			reg_wdata <= d;
			reg_wr <= 1'b1;
			@(posedge clk);
			reg_wr <= 1'b0;
		end
	endtask
	task rd(input [7:0] a, input [31:0] e);
		begin
			@(posedge clk);
			reg_addr <= a;
			reg_rd <= 1'b1;
			@(posedge clk);
			reg_rd <= 1'b0;
			#1 chk(reg_rdata, e);
		end
	endtask
	task lk(input [11:0] v, input [6:0] e);
		begin
			@(posedge clk);
			vq_vid <= v;
			vq_vld <= 1'b1;
			@(posedge clk);
			vq_vld <= 1'b0;
			#1 chk({vq_done, vq_hit, vq_member, vq_tag}, {24'h0, 1'b1, e});
		end
	endtask
	task frm(input [6:0] a, input [7:0] n, input [7:0] x, input [7:0] h, input [2:0] e);
		begin
			@(posedge clk);
			{at, nh, ex, hop} <= {a, n, x, h};
			pk_vld <= 1'b1;
			@(posedge clk);
			pk_vld <= 1'b0;
			#1 chk({pk_done, pk_drop, pk_flood, cpu}, {28'h0, 1'b1, e});
		end
	endtask
	task led(input [7:0] s0, input [7:0] s1, input [5:0] e);
		begin
			@(posedge clk);
			{st0, st1} <= {s0, s1};
			repeat (3) @(posedge clk);
			#1 chk({led1_n, led0_n}, {26'h0, e});
		end
	endtask
	// Main sequence
	initial begin
		{rst_b, reg_wr, reg_rd, send, vq_vld, pk_vld, reg_addr, reg_wdata, vq_vid, at, nh, ex, hop, st0, st1} = 0;
		{mismatches, checks_done, cycles} = 0;
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		for (i = 0; i < 12; i = i + 1) begin
			rd(rad(i), 32'h0000_0000);
			wr(rad(i), 32'hffff_ffff);
			rd(rad(i), msk(i));
		end
		chk({rbeg, wbeg}, 32'h0000_0003);
		wr(8'he0, 32'hffff_ffff);
		rd(8'he0, 32'h0000_0000);
		wr(8'hb1, 32'h0000_0000);
		rd(8'hb0, 32'h0007_ffff);
		for (i = 0; i < 12; i = i + 1)
			wr(rad(i), 32'h0000_0000);
		wr(`SVB_OFF_START, 32'h0000_8000);
		#1 chk({rbeg, wbeg}, 32'h0000_0001);
		for (i = 0; i < 4; i = i + 1) begin
			wr(`SVB_OFF_SWAP, i);
			@(posedge clk);
			send <= 1'b1;
			@(posedge clk);
			send <= 1'b0;
			@(posedge clk);
			#1 chk(host_dout, SWP[32*i +: 32]);
		end
		wr(8'hb0, 32'h0003_ffff);
		wr(8'hb4, 32'h0007_ffd5);
		lk(12'hfff, 7'h6a);
		wr(8'hb0, 32'h0007_ffe3);
		wr(8'hcc, 32'h0004_0049);
		lk(12'hfff, 7'h5c);
		lk(12'h001, 7'h49);
		lk(12'h000, 7'h00);
		wr(`SVB_OFF_MCAST, 32'h0000_0001);
		frm(7'h40, 8'h00, 8'h00, 8'h00, 3'h4);
		wr(`SVB_OFF_MCAST, 32'h0000_0000);
		frm(7'h40, 8'h00, 8'h00, 8'h00, 3'h2);
		frm(7'h10, 8'h00, 8'h00, 8'h00, 3'h4);
		frm(7'h18, 8'h00, 8'h00, 8'h00, 3'h0);
		wr(`SVB_OFF_MCAST, 32'h0000_0002);
		frm(7'h10, 8'h00, 8'h00, 8'h00, 3'h2);
		wr(`SVB_OFF_MCAST, 32'h0000_0010);
		frm(7'h04, 8'h00, 8'h00, 8'h01, 3'h0);
		wr(`SVB_OFF_MCAST, 32'h0000_0090);
		frm(7'h04, 8'h00, 8'h00, 8'h01, 3'h1);
		frm(7'h01, 8'h00, 8'h00, 8'h01, 3'h1);
		frm(7'h04, 8'h00, 8'h00, 8'h02, 3'h0);
		wr(`SVB_OFF_MCAST, 32'h0000_00a0);
		frm(7'h04, 8'h00, 8'h00, 8'h01, 3'h1);
		wr(`SVB_OFF_MCAST, 32'h0000_0084);
		frm(7'h06, 8'h01, 8'h00, 8'h01, 3'h1);
		frm(7'h06, 8'h00, 8'h01, 8'h01, 3'h1);
		frm(7'h06, 8'h01, 8'h00, 8'h02, 3'h0);
		frm(7'h04, 8'h01, 8'h00, 8'h01, 3'h0);
		wr(`SVB_OFF_MCAST, 32'h0000_0088);
		frm(7'h06, 8'h3a, 8'h00, 8'h01, 3'h1);
		frm(7'h06, 8'h00, 8'h3a, 8'h01, 3'h1);
		frm(7'h06, 8'h01, 8'h00, 8'h01, 3'h0);
		wr(`SVB_OFF_MCAST, 32'h0000_00c0);
		for (i = 0; i < 5; i = i + 1)
			frm(7'h04, NHX[8*i +: 8], 8'h00, 8'h05, 3'h1);
		frm(7'h04, 8'h2d, 8'h00, 8'h05, 3'h0);
		wr(`SVB_OFF_IND, 32'h0180_1018);
		led(8'h10, 8'h10, 6'h3c);
		led(8'h81, 8'h00, 6'h3b);
		wr(`SVB_OFF_IND, 32'h0280_1018);
		led(8'h00, 8'h08, 6'h37);
		wr(`SVB_OFF_IND, 32'h0000_1018);
		led(8'h18, 8'h18, 6'h3f);
		wr(`SVB_OFF_IND, 32'h0300_1018);
		led(8'h18, 8'h18, 6'h24);
		end_sim;
	end
endmodule
`default_nettype wire
